// ==== cic_pkg.sv ====
// constants shared by the core interrupt control block
package cic_pkg;
  // register indices, byte address is four times the index
  localparam logic [11:0] IDX_IRQ_CONTROL = 12'h00b;
  localparam logic [11:0] IDX_PERIPH_FLAG = 12'h00c;
  localparam logic [11:0] IDX_PERIPH_EN   = 12'h08c;
  localparam logic [11:0] IDX_EVT_STATUS  = 12'h090;
  localparam logic [11:0] IDX_EVT_CLEAR   = 12'h091;
  localparam logic [11:0] IDX_EVT_ENABLE  = 12'h092;
  // control register fields
  localparam int GLOBAL_EN_BIT  = 7;
  localparam int GROUP_EN_BIT   = 6;
  localparam int TIMER_EN_BIT   = 5;
  localparam int PIN_EN_BIT     = 4;
  localparam int PORT_EN_BIT    = 3;
  localparam int TIMER_FLAG_BIT = 2;
  localparam int PIN_FLAG_BIT   = 1;
  localparam int PORT_FLAG_BIT  = 0;
  // peripheral flag and enable fields
  localparam int PARALLEL_BIT = 7;
  localparam int CMP_BIT  = 6;
  localparam logic [7:0] PERIPH_MASK = 8'hc0;
  // event status fields
  localparam int EVT_VECTOR = 0;
  localparam int EVT_RETURN = 1;
  localparam logic [1:0] EVT_MASK = 2'h3;
  // reset values
  localparam logic [7:0] IRQ_CONTROL_RST = 8'h00;
  localparam logic [7:0] PERIPH_RST      = 8'h00;
  // vector target of the program counter
  localparam logic [12:0] VECTOR_ADDR = 13'h0004;
  // instruction cycle timing
  localparam int CLK_MHZ          = 100;
  localparam int ICYCLE_NS        = 40;
  localparam int CLKS_PER_ICYCLE  = ICYCLE_NS * CLK_MHZ / 1000;
  localparam logic [1:0] DIV_LAST = 2'(CLKS_PER_ICYCLE - 1);
  // instruction boundaries between request sample and vector
  localparam logic [1:0] VEC_DELAY = 2'h2;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== cic_core_irq.sv ====
// interrupt control for the microcontroller core, with axi4-lite registers
//
// Operation
// - five sources: pin, timer, port, comparator, parallel
// - global enable bit 7 gates all
// - reset clears global enable
// - return op sets global enable
// - each source masked by own enable
// - peripheral group enable gates peripheral sources
// - peripheral flags and enables separate registers
// - accept: clear enable, push, vector 0004h
// - pin events vector three to four cycles
// - flags set regardless of any enable
// - clearing global enable drops next request, nop
// - dropped requests stay pending
`timescale 1ns/1ps
module cic_core_irq
  import cic_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        external_irq_pin,
  input  wire logic [3:0]  port_change_pins,
  input  wire logic        timer_zero_ovf,
  input  wire logic        comparator_event,
  input  wire logic        parallel_port_event,
  input  wire logic        return_from_irq_op,
  output logic             icycle_tick,
  output logic             vector_take,
  output logic             stack_push,
  output logic [12:0]      pc_load_value,
  output logic             insert_nop,
  output logic             irq
);

  //----------------------------------------------------------------
  // instruction cycle divider
  //----------------------------------------------------------------
  logic [1:0] div_reg;

  // one enable pulse per instruction cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || div_reg == DIV_LAST) begin
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_reg + 2'h1;
    end
  end
  assign icycle_tick = (div_reg == DIV_LAST);

  //----------------------------------------------------------------
  // pin synchronisers
  //----------------------------------------------------------------
  logic [4:0] s1_reg, s2_reg, s3_reg, pin_reg;
  wire  [4:0] pin_raw = {port_change_pins, external_irq_pin};
  wire        pins_agree = (s2_reg == s3_reg);

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg  <= 5'h00;
      s2_reg  <= 5'h00;
      s3_reg  <= 5'h00;
      pin_reg <= 5'h00;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (pins_agree) begin
        pin_reg <= s3_reg;
      end
    end
  end

  wire ext_event  = pins_agree && s3_reg[0] && !pin_reg[0];
  wire port_event = pins_agree && (s3_reg[4:1] != pin_reg[4:1]);

  //----------------------------------------------------------------
  // axi4-lite write side
  //----------------------------------------------------------------
  logic        aw_held_reg, w_held_reg;
  logic [11:0] aw_addr_reg;
  logic [7:0]  w_data_reg;
  logic        w_lane_reg;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;

  wire        wr_fire  = aw_held_reg && w_held_reg;
  wire [11:0] wr_idx   = {2'h0, aw_addr_reg[11:2]};
  wire        wr_ok    = (aw_addr_reg[1:0] == 2'h0) && w_lane_reg;
  wire        wr_ctl   = wr_fire && wr_ok && wr_idx == IDX_IRQ_CONTROL;
  wire        wr_pflag = wr_fire && wr_ok && wr_idx == IDX_PERIPH_FLAG;
  wire        wr_pen   = wr_fire && wr_ok && wr_idx == IDX_PERIPH_EN;
  wire        wr_eclr  = wr_fire && wr_ok && wr_idx == IDX_EVT_CLEAR;
  wire        wr_een   = wr_fire && wr_ok && wr_idx == IDX_EVT_ENABLE;
  wire        wr_hit   = wr_ctl || wr_pflag || wr_pen || wr_eclr || wr_een;

  // address and data are taken in either order, answer after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      aw_addr_reg  <= 12'h000;
      w_data_reg   <= 8'h00;
      w_lane_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  //----------------------------------------------------------------
  // interrupt registers
  //----------------------------------------------------------------
  logic [7:0] ctl_reg, pflag_reg, pen_reg;
  logic [1:0] evt_sts_reg, evt_en_reg;
  logic [1:0] stage_reg;
  logic       vec_pulse_reg;

  // each core source masked by its own enable
  // request needs global enable and an enabled source
  wire core_req = (ctl_reg[TIMER_EN_BIT] && ctl_reg[TIMER_FLAG_BIT])
               || (ctl_reg[PIN_EN_BIT] && ctl_reg[PIN_FLAG_BIT])
               || (ctl_reg[PORT_EN_BIT] && ctl_reg[PORT_FLAG_BIT]);
  // peripheral group gates comparator and parallel port
  wire per_req  = ctl_reg[GROUP_EN_BIT] && |(pflag_reg & pen_reg & PERIPH_MASK);
  // global enable blocks everything when low
  wire irq_req  = ctl_reg[GLOBAL_EN_BIT] && (core_req || per_req);
  // a write that drops global enable
  wire en_drop  = wr_ctl && ctl_reg[GLOBAL_EN_BIT] && !w_data_reg[GLOBAL_EN_BIT];
  // vector on the boundary after the delay stages
  wire take     = icycle_tick && irq_req && !en_drop && stage_reg == VEC_DELAY;

  // events raise flags whatever the enables
  wire [7:0] ctl_set = {5'h00, timer_zero_ovf, ext_event, port_event};
  wire [7:0] pf_set  = {parallel_port_event, comparator_event, 6'h00};
  wire [1:0] evt_set = {return_from_irq_op, take};

  // flags only drop by software write; set wins over clear
  wire [7:0] ctl_sw  = wr_ctl ? w_data_reg : ctl_reg;
  wire [7:0] ctl_clr = take ? (ctl_sw & ~(8'h01 << GLOBAL_EN_BIT)) : ctl_sw;
  wire [7:0] ctl_next = return_from_irq_op ? (ctl_clr | (8'h01 << GLOBAL_EN_BIT))
                                           : (ctl_clr | ctl_set);
  wire [7:0] pflag_next = ((wr_pflag ? w_data_reg : pflag_reg) | pf_set)
                          & PERIPH_MASK;
  wire [1:0] evt_next = (evt_sts_reg & ~(wr_eclr ? w_data_reg[1:0] : 2'h0))
                        | evt_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_reg     <= IRQ_CONTROL_RST;
      pflag_reg   <= PERIPH_RST;
      pen_reg     <= PERIPH_RST;
      evt_sts_reg <= 2'h0;
      evt_en_reg  <= 2'h0;
    end else begin
      ctl_reg[7:3] <= ctl_next[7:3];
      ctl_reg[2:0] <= ctl_next[2:0] | ctl_set[2:0];
      // peripheral flags and enables in own registers
      pflag_reg   <= pflag_next;
      pen_reg     <= wr_pen ? (w_data_reg & PERIPH_MASK) : pen_reg;
      evt_sts_reg <= evt_next;
      evt_en_reg  <= wr_een ? (w_data_reg[1:0] & EVT_MASK) : evt_en_reg;
    end
  end

  //----------------------------------------------------------------
  // vectoring pipeline
  //----------------------------------------------------------------
  // dropped requests restart from the flags later
  always_ff @(posedge aclk) begin
    if (!aresetn || en_drop || take) begin
      stage_reg <= 2'h0;
    end else if (icycle_tick) begin
      stage_reg <= irq_req ? ((stage_reg == VEC_DELAY) ? stage_reg
                                                       : stage_reg + 2'h1)
                           : 2'h0;
    end
  end

  // clear enable, push return address, load vector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vec_pulse_reg <= 1'b0;
      insert_nop    <= 1'b0;
      pc_load_value <= 13'h0000;
    end else begin
      vec_pulse_reg <= take;
      insert_nop    <= en_drop;
      pc_load_value <= VECTOR_ADDR;
    end
  end
  assign vector_take = vec_pulse_reg;
  assign stack_push  = vec_pulse_reg;
  assign irq         = |(evt_sts_reg & evt_en_reg);

  //----------------------------------------------------------------
  // axi4-lite read side
  //----------------------------------------------------------------
  wire [11:0] rd_idx = {2'h0, s_axi_araddr[11:2]};
  wire        rd_al  = (s_axi_araddr[1:0] == 2'h0);
  wire [7:0]  rd_val = (rd_idx == IDX_IRQ_CONTROL) ? ctl_reg
                     : (rd_idx == IDX_PERIPH_FLAG) ? pflag_reg
                     : (rd_idx == IDX_PERIPH_EN)   ? pen_reg
                     : (rd_idx == IDX_EVT_STATUS)  ? {6'h00, evt_sts_reg}
                     : (rd_idx == IDX_EVT_ENABLE)  ? {6'h00, evt_en_reg}
                     : 8'h00;
  wire        rd_hit = rd_al && (rd_idx == IDX_IRQ_CONTROL
                     || rd_idx == IDX_PERIPH_FLAG || rd_idx == IDX_PERIPH_EN
                     || rd_idx == IDX_EVT_STATUS || rd_idx == IDX_EVT_ENABLE);

  assign s_axi_arready = !s_axi_rvalid;

  // read data registered one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_hit ? rd_val : 8'h00};
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  //----------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------
  a_enable_reset: assert property (@(posedge aclk)
    !aresetn |=> !ctl_reg[GLOBAL_EN_BIT]) else $error("global enable set after reset");

  a_take_needs_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    vector_take |-> $past(ctl_reg[GLOBAL_EN_BIT])) else $error("vector without enable");

  a_take_clears_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    take && !return_from_irq_op |=> !ctl_reg[GLOBAL_EN_BIT] && vector_take
    && stack_push && pc_load_value == VECTOR_ADDR) else $error("vector effects wrong");

  a_return_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    return_from_irq_op |=> ctl_reg[GLOBAL_EN_BIT]) else $error("return did not enable");

  a_periph_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    take && !core_req |-> ctl_reg[GROUP_EN_BIT]) else $error("peripheral vector ungated");

  a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_reg[PIN_FLAG_BIT] && !wr_ctl |=> ctl_reg[PIN_FLAG_BIT]) else $error("flag lost");

  a_timer_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_zero_ovf |=> ctl_reg[TIMER_FLAG_BIT]) else $error("timer flag not set");

  a_drop_nop: assert property (@(posedge aclk) disable iff (!aresetn)
    en_drop |-> !take ##1 insert_nop) else $error("drop not honoured");

  a_vector_latency: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(irq_req) && stage_reg == 2'h0 && !en_drop |-> ##[1:4]
    (stage_reg != 2'h0 || !irq_req)) else $error("vector pipeline stalled");

endmodule

// ==== cic_core_model.sv ====
// processor core stand-in: counts stack depth, captures the vector, issues returns
`timescale 1ns/1ps
module cic_core_model
  import cic_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        vector_take,
  input  wire logic        stack_push,
  input  wire logic [12:0] pc_load_value,
  input  wire logic        insert_nop,
  input  wire logic        ret_req,
  output logic             return_from_irq_op,
  output logic [3:0]       depth,
  output logic [12:0]      pc_now,
  output logic [7:0]       nop_count
);
  // --------------------------------------------------------------
  // sequencer and stack
  // --------------------------------------------------------------
  // push and jump
  // return pops stack; only issued with something on it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      return_from_irq_op <= 1'b0;
      depth              <= 4'h0;
      pc_now             <= 13'h0000;
      nop_count          <= 8'h00;
    end else begin
      return_from_irq_op <= ret_req && (depth != 4'h0);
      depth              <= depth + 4'(stack_push) - 4'(return_from_irq_op);
      if (vector_take) pc_now <= pc_load_value;
      if (insert_nop) nop_count <= nop_count + 8'h01;
    end
  end
endmodule

// ==== tb_core_interrupt_control.sv ====
// self-checking bench for the core interrupt control block
`timescale 1ns/1ps
module tb_core_interrupt_control;
  import cic_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, pin, tmr, cmp, par, ret, ret_req;
  logic        tick, vt, sp, nop, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb, pins, depth;
  logic [1:0]  bresp, rresp, r;
  logic [12:0] pc, pc_now;
  logic [7:0]  nop_count, ectl, epf;
  int          seed, n_mismatch, n_compared, n_vec, i, s, k;

  cic_core_irq u_cic_core_irq (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_irq_pin(pin), .port_change_pins(pins), .timer_zero_ovf(tmr),
    .comparator_event(cmp), .parallel_port_event(par), .return_from_irq_op(ret),
    .icycle_tick(tick), .vector_take(vt), .stack_push(sp), .pc_load_value(pc),
    .insert_nop(nop), .irq(irq));
  cic_core_model u_cic_core_model (.aclk(aclk), .aresetn(aresetn), .vector_take(vt),
    .stack_push(sp), .pc_load_value(pc), .insert_nop(nop), .ret_req(ret_req),
    .return_from_irq_op(ret), .depth(depth), .pc_now(pc_now), .nop_count(nop_count));

  // --------------------------------------------------------------
  // clock, watchdog, monitors
  // --------------------------------------------------------------
  always #5 aclk = ~aclk;
  always @(posedge aclk) if (vt === 1'b1) n_vec <= n_vec + 1;
  // whole run is a few hundred cycles; twenty thousand means a hang
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [11:0] ba(input logic [11:0] idx);
    return {idx[9:0], 2'b00};
  endfunction
  function automatic logic [7:0] fl_ctl(input int src);
    return src == 0 ? 8'(1 << PIN_FLAG_BIT) : src == 1 ? 8'(1 << PORT_FLAG_BIT) :
           src == 2 ? 8'(1 << TIMER_FLAG_BIT) : 8'h00;
  endfunction
  function automatic logic [7:0] fl_pf(input int src);
    return src == 3 ? 8'(1 << CMP_BIT) : src == 4 ? 8'(1 << PARALLEL_BIT) : 8'h00;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // releases end with one spare edge so the next call never re-drives in the same step
  // waits are open ended; only the watchdog ends a hung transfer
  task automatic wr(input logic [11:0] idx, input logic [7:0] v);
    awaddr <= ba(idx); awvalid <= 1'b1; wdata <= {24'h0, v}; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk(bresp, RESP_OKAY);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] idx, output logic [31:0] v, output logic [1:0] rr);
    araddr <= ba(idx); arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata; rr = rresp; rready <= 1'b0;
    @(posedge aclk);
  endtask
  // pulse one source; the pin is held long enough to pass its synchroniser
  task automatic ev(input int src);
    case (src)
      0: pin <= 1'b1;
      1: pins <= pins ^ (4'($random(seed)) | 4'h1);
      2: tmr <= 1'b1;
      3: cmp <= 1'b1;
      default: par <= 1'b1;
    endcase
    @(posedge aclk);
    tmr <= 1'b0; cmp <= 1'b0; par <= 1'b0;
    repeat (8) @(posedge aclk);
    pin <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask
  task automatic wait_vec(input int target);
    k = 0;
    while (n_vec < target && k < 80) begin
      @(posedge aclk);
      k++;
    end
  endtask
  task automatic stop_test();
    $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    aclk = 0; aresetn = 0; seed = 43557; n_mismatch = 0; n_compared = 0; n_vec = 0;
    awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0; awaddr = 0; araddr = 0;
    wdata = 0; wstrb = 4'h1; pin = 0; pins = 0; tmr = 0; cmp = 0; par = 0; ret_req = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(IDX_IRQ_CONTROL, d, r); chk(d, 32'(IRQ_CONTROL_RST));
    rd(12'h0ff, d, r); chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    chk(irq, 0);
    // instruction boundary pulse spacing
    do @(posedge aclk); while (tick !== 1'b1);
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (tick !== 1'b1 && k < 8);
    chk(k, CLKS_PER_ICYCLE);
    $display("test reset done");
    // every source once, then random ones, all enables off
    ectl = 0; epf = 0;
    for (i = 0; i < 8; i++) begin
      s = i < 5 ? i : $unsigned($random(seed)) % 5;
      ev(s);
      ectl |= fl_ctl(s); epf |= fl_pf(s);
    end
    rd(IDX_IRQ_CONTROL, d, r); chk(d, 32'(ectl));
    rd(IDX_PERIPH_FLAG, d, r); chk(d, 32'(epf));
    chk(n_vec, 0);
    $display("test flags done");
    // peripheral group gate, then acceptance
    wr(IDX_EVT_ENABLE, 8'h01); wr(IDX_PERIPH_EN, 8'hc0); wr(IDX_IRQ_CONTROL, 8'h80);
    repeat (40) @(posedge aclk);
    chk(n_vec, 0);
    wr(IDX_IRQ_CONTROL, 8'hc0); wait_vec(1);
    chk(n_vec, 1);
    rd(IDX_IRQ_CONTROL, d, r); chk(d, 32'h40);
    chk(depth, 1);
    chk(pc_now, VECTOR_ADDR);
    rd(IDX_PERIPH_FLAG, d, r); chk(d, 32'hc0);
    chk(irq, 1);
    wr(IDX_EVT_ENABLE, 8'h00); chk(irq, 0);
    wr(IDX_EVT_ENABLE, 8'h01); wr(IDX_EVT_CLEAR, 8'h01); chk(irq, 0);
    wr(IDX_PERIPH_FLAG, 8'h00);
    ret_req <= 1'b1; @(posedge aclk); ret_req <= 1'b0; repeat (4) @(posedge aclk);
    rd(IDX_IRQ_CONTROL, d, r); chk(d, 32'hc0);
    rd(IDX_EVT_STATUS, d, r); chk(d, 32'h02);
    repeat (40) @(posedge aclk);
    chk(n_vec, 1);
    $display("test accept done");
    // enable dropped while a request is on its way
    wr(IDX_IRQ_CONTROL, 8'ha0); tmr <= 1'b1; @(posedge aclk); tmr <= 1'b0;
    wr(IDX_IRQ_CONTROL, 8'h24); repeat (30) @(posedge aclk);
    chk(n_vec, 1);
    chk(nop_count, 1);
    rd(IDX_IRQ_CONTROL, d, r); chk(d, 32'h24);
    wr(IDX_IRQ_CONTROL, 8'h84); repeat (30) @(posedge aclk);
    chk(n_vec, 1);
    wr(IDX_IRQ_CONTROL, 8'ha4); wait_vec(2);
    chk(n_vec, 2);
    $display("test pending done");
    // pin latency; vector_take is registered one clock past the take
    wr(IDX_IRQ_CONTROL, 8'h90); pin <= 1'b1; k = 0;
    while (vt !== 1'b1 && k < 40) begin
      @(posedge aclk);
      k++;
    end
    chk(k - 1 >= 12 && k - 1 <= 16, 1);
    $display("test latency done");
    stop_test();
  end
endmodule
